//--- logic/rpm_pkg.sv
// Package for the RF protocol mode configuration register bank.
// Assumes an APB slave with 32-bit data; registers occupy aligned words.
package rpm_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] RPM_IDX_OP_CTRL = 8'h02;
  localparam logic [7:0] RPM_IDX_MODE = 8'h03;
  localparam logic [7:0] RPM_IDX_RATE = 8'h04;
  localparam logic [7:0] RPM_IDX_TYPEA = 8'h05;
  localparam int RPM_ADDR_W = 12;
  localparam int RPM_ADDR_SHIFT = 2;

  // Mode definition fields
  localparam int RPM_MODE_ROLE = 7;
  localparam int RPM_MODE_OP_HI = 6;
  localparam int RPM_MODE_OP_LO = 3;
  localparam int RPM_MODE_MOD = 2;
  localparam int RPM_MODE_AR_HI = 1;
  localparam int RPM_MODE_AR_LO = 0;
  localparam logic [7:0] RPM_MODE_RST = 8'h08;
  localparam logic [7:0] RPM_MODE_MASK = 8'hFF;

  // Bit rate fields
  localparam int RPM_TX_HI = 5;
  localparam int RPM_TX_LO = 4;
  localparam int RPM_RX_HI = 1;
  localparam int RPM_RX_LO = 0;
  localparam logic [7:0] RPM_RATE_RST = 8'h00;
  localparam logic [7:0] RPM_RATE_MASK = 8'h33;

  // Type-A settings fields
  localparam int RPM_A_NO_TX_PAR = 7;
  localparam int RPM_A_RAW_RX_PAR = 6;
  localparam int RPM_A_FRAME_FMT = 5;
  localparam int RPM_A_PW_HI = 4;
  localparam int RPM_A_PW_LO = 1;
  localparam int RPM_A_ANTICOLL = 0;
  localparam logic [7:0] RPM_TYPEA_RST = 8'h00;
  localparam logic [7:0] RPM_TYPEA_MASK = 8'hFF;

  // Operation control: only power-up defaults
  localparam logic [7:0] RPM_OPCTL_RST = 8'h00;
  localparam logic [7:0] RPM_OPCTL_MASK = 8'hFF;

  // Start byte inserted with transport frame format
  localparam logic [7:0] RPM_START_BYTE = 8'hF0;

  // Pulse width at carrier/128: code 0 gives this, codes 1..7 add, 8..15 continue below
  localparam logic [5:0] RPM_PW_BASE = 6'd35;
  localparam logic [5:0] RPM_PW_WRAP = 6'd43;

  typedef enum logic [1:0] {
    RPM_RATE_128 = 2'b00,
    RPM_RATE_64 = 2'b01,
    RPM_RATE_32 = 2'b10,
    RPM_RATE_16 = 2'b11
  } rpm_rate_e;

  typedef enum logic [3:0] {
    RPM_OM_P2P = 4'b0000,
    RPM_OM_A = 4'b0001,
    RPM_OM_B = 4'b0010,
    RPM_OM_F = 4'b0011,
    RPM_OM_T1T = 4'b0100,
    RPM_OM_SUBC = 4'b1110,
    RPM_OM_BPSK = 4'b1111
  } rpm_init_om_e;

  localparam logic [3:0] RPM_TM_A = 4'b0001;
  localparam logic [3:0] RPM_TM_F = 4'b0100;
  localparam logic [3:0] RPM_TM_P2P = 4'b0111;
  localparam int RPM_TM_DET_BIT = 3;
  localparam int RPM_TM_DET_F = 2;
  localparam int RPM_TM_DET_A = 0;

  // Decoded mode binary index
  typedef enum logic [3:0] {
    RPM_SEL_NONE = 4'b0000,
    RPM_SEL_P2P = 4'b0001,
    RPM_SEL_A = 4'b0010,
    RPM_SEL_B = 4'b0011,
    RPM_SEL_F = 4'b0100,
    RPM_SEL_T1T = 4'b0101,
    RPM_SEL_SUBC = 4'b0110,
    RPM_SEL_BPSK = 4'b0111,
    RPM_SEL_TA = 4'b1000,
    RPM_SEL_TF = 4'b1001,
    RPM_SEL_TP2P = 4'b1010,
    RPM_SEL_DET = 4'b1011
  } rpm_sel_e;
endpackage : rpm_pkg

//--- logic/rpm_config.sv
// Mode, bit rate and type-A configuration registers behind an APB slave.
// Assumes clock_i at 40 MHz, crystal-OK and power-up reset from the analog core.
`timescale 1ns/10ps
// Function
// - Mode bit 7 picks initiator (0) or target (1); mode field decoded per role.
// - Initiator codes: P2P, A, B, F, type 1, sub-carrier, BPSK; rest reserved.
// - Unsupported mode code for the role disables transmit and receive.
// - Target codes: A passive, F passive, active P2P; other low codes disallowed.
// - Target code with top bit selects rate detection; bit2 F, bit0 A, bit1 reserved.
// - Passive target and detection modes modulate through the passive target resistance.
// - Mode bit 2 picks on-off keying (0) or amplitude modulation (1).
// - Mode register writes accepted only while crystal OK is high.
// - Mode register resets to role 0, modulation 0, response 00, mode 0001.
// - Bit rate register: transmit rate 5:4, receive rate 1:0, others reserved, reset 0.
// - Rate codes: carrier/128, /64, /32, /16.
// - Rate unsupported in current mode disables transmit and receive.
// - Suppress transmit parity sends FIFO data without parity; host uses no-CRC transmit.
// - Raw receive parity stores stream with parity unchecked; 106 kbit/s only.
// - Transport frame format adds start byte F0 and length; strips start byte on receive.
// - Pulse width field bits 4:1 sets type-A pulse in carrier periods.
// - At carrier/128 codes 0..7 give 35..42, codes 8..15 give 27..34.
// - Operation control register takes defaults only at power-up.
module rpm_config
  import rpm_pkg::*;
(
  input wire logic clock_i, // 40 MHz clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic por_n_i, // Power-up reset, active low
  input wire logic xtal_ok_i, // Crystal clock present and stable
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  output logic role_target_o, // 1 target role
  output logic [3:0] op_mode_o, // Raw operating-mode field
  output logic [3:0] mode_sel_o, // Decoded mode (rpm_sel_e)
  output logic rate_det_f_o, // Type F rate detection enabled
  output logic rate_det_a_o, // Type A rate detection enabled
  output logic modulation_type_sel_o, // 0 OOK, 1 AM
  output logic [1:0] auto_response_o, // Automatic response field control
  output logic use_passive_target_load_res_o, // Load modulation via passive target resistance
  output logic [1:0] transmit_speed_o, // Transmit rate selector
  output logic [1:0] receive_speed_o, // Receive rate selector
  output logic txrx_enable_o, // Transmit/receive permitted
  output logic no_tx_parity_o, // Suppress transmit parity
  output logic raw_rx_parity_o, // Raw receive with parity
  output logic transport_frame_format_o, // Transport frame format active
  output logic [7:0] start_byte_o, // Start byte for transport frame
  output logic [3:0] pulse_width_code_o, // Pulse width code
  output logic [5:0] pulse_width_periods_o, // Pulse width at carrier/128 in carrier periods
  output logic anticoll_frame_o, // Anticollision framing
  output logic [7:0] op_ctrl_o // Operation control register
);

  logic [7:0] mode_r;
  logic [7:0] rate_r;
  logic [7:0] typea_r;
  logic [7:0] opctl_r;
  logic [7:0] rd_nxt;
  logic hit_nxt;
  logic mode_ok;
  logic rate_ok;
  rpm_sel_e sel;

  localparam int IDX_W = $bits(RPM_IDX_MODE);

  // Word index decode shared by write and read paths
  function automatic logic [IDX_W-1:0] reg_index(input logic [11:0] addr);
    return addr[RPM_ADDR_SHIFT +: IDX_W];
  endfunction : reg_index

  // Aligned word with the address bits above the index at zero, so no register aliases higher up
  function automatic logic is_aligned(input logic [11:0] addr);
    return (addr[RPM_ADDR_SHIFT-1:0] == '0) && (addr[RPM_ADDR_W-1:RPM_ADDR_SHIFT+IDX_W] == '0);
  endfunction : is_aligned

  // Decode of role and operating mode
  function automatic rpm_sel_e decode_mode(input logic [7:0] m);
    logic [3:0] om;
    om = m[RPM_MODE_OP_HI:RPM_MODE_OP_LO];
    decode_mode = RPM_SEL_NONE;
    if (!m[RPM_MODE_ROLE]) begin
      unique case (om)
        RPM_OM_P2P: decode_mode = RPM_SEL_P2P;
        RPM_OM_A: decode_mode = RPM_SEL_A;
        RPM_OM_B: decode_mode = RPM_SEL_B;
        RPM_OM_F: decode_mode = RPM_SEL_F;
        RPM_OM_T1T: decode_mode = RPM_SEL_T1T;
        RPM_OM_SUBC: decode_mode = RPM_SEL_SUBC;
        RPM_OM_BPSK: decode_mode = RPM_SEL_BPSK;
        default: decode_mode = RPM_SEL_NONE;
      endcase
    end else if (om[RPM_TM_DET_BIT]) begin
      decode_mode = RPM_SEL_DET;
    end else begin
      unique case (om)
        RPM_TM_A: decode_mode = RPM_SEL_TA;
        RPM_TM_F: decode_mode = RPM_SEL_TF;
        RPM_TM_P2P: decode_mode = RPM_SEL_TP2P;
        default: decode_mode = RPM_SEL_NONE;
      endcase
    end
    return decode_mode;
  endfunction : decode_mode

  assign sel = decode_mode(mode_r);

  // Rate support per mode: raw parity needs 106k, type 1 and card emulation at 106k only
  always_comb begin
    rate_ok = 1'b1;
    unique case (sel)
      RPM_SEL_T1T, RPM_SEL_TA: rate_ok = (rate_r[RPM_TX_HI:RPM_TX_LO] == RPM_RATE_128) &&
                                         (rate_r[RPM_RX_HI:RPM_RX_LO] == RPM_RATE_128);
      RPM_SEL_F, RPM_SEL_TF: rate_ok = (rate_r[RPM_TX_HI:RPM_TX_LO] != RPM_RATE_128) &&
                                       (rate_r[RPM_TX_HI:RPM_TX_LO] != RPM_RATE_16) &&
                                       (rate_r[RPM_RX_HI:RPM_RX_LO] != RPM_RATE_128) &&
                                       (rate_r[RPM_RX_HI:RPM_RX_LO] != RPM_RATE_16);
      RPM_SEL_P2P, RPM_SEL_TP2P: rate_ok = (rate_r[RPM_TX_HI:RPM_TX_LO] != RPM_RATE_16) &&
                                           (rate_r[RPM_RX_HI:RPM_RX_LO] != RPM_RATE_16);
      default: rate_ok = 1'b1;
    endcase
    if (typea_r[RPM_A_RAW_RX_PAR] && (rate_r[RPM_RX_HI:RPM_RX_LO] != RPM_RATE_128)) begin
      rate_ok = 1'b0;
    end
  end

  assign mode_ok = (sel != RPM_SEL_NONE);

  // Mode register: writes need a stable crystal clock
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= RPM_MODE_RST;
    end else if (psel_i && penable_i && pwrite_i && is_aligned(paddr_i) &&
                 reg_index(paddr_i) == RPM_IDX_MODE && xtal_ok_i) begin
      mode_r <= pwdata_i[7:0] & RPM_MODE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_r <= RPM_RATE_RST;
    end else if (psel_i && penable_i && pwrite_i && is_aligned(paddr_i) &&
                 reg_index(paddr_i) == RPM_IDX_RATE) begin
      rate_r <= pwdata_i[7:0] & RPM_RATE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      typea_r <= RPM_TYPEA_RST;
    end else if (psel_i && penable_i && pwrite_i && is_aligned(paddr_i) &&
                 reg_index(paddr_i) == RPM_IDX_TYPEA) begin
      typea_r <= pwdata_i[7:0] & RPM_TYPEA_MASK;
    end
  end

  // Operation control keeps its value across ordinary reset
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      opctl_r <= RPM_OPCTL_RST;
    end else if (psel_i && penable_i && pwrite_i && is_aligned(paddr_i) &&
                 reg_index(paddr_i) == RPM_IDX_OP_CTRL) begin
      opctl_r <= pwdata_i[7:0] & RPM_OPCTL_MASK;
    end
  end

  // Read mux; unmapped or unaligned addresses answer with an error
  always_comb begin
    rd_nxt = 8'h00;
    hit_nxt = is_aligned(paddr_i);
    unique case (reg_index(paddr_i))
      RPM_IDX_OP_CTRL: rd_nxt = opctl_r;
      RPM_IDX_MODE: rd_nxt = mode_r;
      RPM_IDX_RATE: rd_nxt = rate_r & RPM_RATE_MASK;
      RPM_IDX_TYPEA: rd_nxt = typea_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  // Zero-wait APB answer: pready and data registered during setup
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      pslverr_o <= !hit_nxt;
      prdata_o <= (hit_nxt && !pwrite_i) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Registered configuration outputs
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      role_target_o <= 1'b0;
      op_mode_o <= RPM_MODE_RST[RPM_MODE_OP_HI:RPM_MODE_OP_LO];
      mode_sel_o <= RPM_SEL_A;
      rate_det_f_o <= 1'b0;
      rate_det_a_o <= 1'b0;
      modulation_type_sel_o <= 1'b0;
      auto_response_o <= 2'b00;
      use_passive_target_load_res_o <= 1'b0;
      transmit_speed_o <= RPM_RATE_128;
      receive_speed_o <= RPM_RATE_128;
      txrx_enable_o <= 1'b0;
    end else begin
      role_target_o <= mode_r[RPM_MODE_ROLE];
      op_mode_o <= mode_r[RPM_MODE_OP_HI:RPM_MODE_OP_LO];
      mode_sel_o <= sel;
      rate_det_f_o <= (sel == RPM_SEL_DET) && mode_r[RPM_MODE_OP_LO+RPM_TM_DET_F];
      rate_det_a_o <= (sel == RPM_SEL_DET) && mode_r[RPM_MODE_OP_LO+RPM_TM_DET_A];
      modulation_type_sel_o <= mode_r[RPM_MODE_MOD];
      // Reserved response code 11 is treated as off
      auto_response_o <= (mode_r[RPM_MODE_AR_HI:RPM_MODE_AR_LO] == 2'b11) ? 2'b00 :
                         mode_r[RPM_MODE_AR_HI:RPM_MODE_AR_LO];
      use_passive_target_load_res_o <= (sel == RPM_SEL_TA) || (sel == RPM_SEL_TF) ||
                                       (sel == RPM_SEL_DET);
      transmit_speed_o <= rate_r[RPM_TX_HI:RPM_TX_LO];
      receive_speed_o <= rate_r[RPM_RX_HI:RPM_RX_LO];
      txrx_enable_o <= mode_ok && rate_ok;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      no_tx_parity_o <= 1'b0;
      raw_rx_parity_o <= 1'b0;
      transport_frame_format_o <= 1'b0;
      start_byte_o <= RPM_START_BYTE;
      pulse_width_code_o <= 4'h0;
      pulse_width_periods_o <= RPM_PW_BASE;
      anticoll_frame_o <= 1'b0;
    end else begin
      no_tx_parity_o <= typea_r[RPM_A_NO_TX_PAR];
      raw_rx_parity_o <= typea_r[RPM_A_RAW_RX_PAR];
      // Frame format blocked in detection mode as a guard against host misuse
      transport_frame_format_o <= typea_r[RPM_A_FRAME_FMT] && (sel != RPM_SEL_DET);
      start_byte_o <= RPM_START_BYTE;
      pulse_width_code_o <= typea_r[RPM_A_PW_HI:RPM_A_PW_LO];
      pulse_width_periods_o <= typea_r[RPM_A_PW_HI] ?
        6'(RPM_PW_WRAP - 6'd16 + {3'b000, typea_r[RPM_A_PW_HI-1:RPM_A_PW_LO]}) :
        6'(RPM_PW_BASE + {3'b000, typea_r[RPM_A_PW_HI-1:RPM_A_PW_LO]});
      anticoll_frame_o <= typea_r[RPM_A_ANTICOLL];
    end
  end

  // Operation control mirror follows only the power-up reset
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      op_ctrl_o <= RPM_OPCTL_RST;
    end else begin
      op_ctrl_o <= opctl_r;
    end
  end

endmodule : rpm_config

//--- tb/rpm_config_checker.sv
// Concurrent checks on the APB port and configuration outputs of rpm_config.
// Bound to rpm_config; sees only its ports.
`timescale 1ns/10ps
module rpm_config_checker
  import rpm_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic xtal_ok_i, // Crystal stable
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic role_target_o, // Role
  input wire logic [3:0] op_mode_o, // Mode field
  input wire logic [3:0] mode_sel_o, // Decoded mode
  input wire logic modulation_type_sel_o, // Modulation
  input wire logic [1:0] transmit_speed_o, // Tx rate
  input wire logic [1:0] receive_speed_o, // Rx rate
  input wire logic txrx_enable_o // Tx/Rx allowed
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic acc;
  logic wr_mode;
  logic wr_rate;
  logic mapped;
  assign acc = psel_i && penable_i && pready_o && pwrite_i;
  assign wr_mode = acc && paddr_i == 12'h00C;
  assign wr_rate = acc && paddr_i == 12'h010;
  assign mapped = paddr_i inside {12'h008, 12'h00C, 12'h010, 12'h014};
  ready_timing_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  addr_error_a: assert property (pready_o |-> pslverr_o == !mapped) else $error("error flag wrong");
  mode_write_a: assert property (wr_mode && xtal_ok_i |-> ##2 role_target_o == $past(pwdata_i[7], 2) &&
    op_mode_o == $past(pwdata_i[6:3], 2) && modulation_type_sel_o == $past(pwdata_i[2], 2))
    else $error("mode write not applied");
  mode_lock_a: assert property (wr_mode && !xtal_ok_i |-> ##2 op_mode_o == $past(op_mode_o, 2) &&
    role_target_o == $past(role_target_o, 2)) else $error("mode written without crystal");
  rate_write_a: assert property (wr_rate |-> ##2 transmit_speed_o == $past(pwdata_i[5:4], 2) &&
    receive_speed_o == $past(pwdata_i[1:0], 2)) else $error("rate write not applied");
  reset_mode_a: assert property ($rose(reset_n_i) |-> op_mode_o == 4'h1 && !role_target_o &&
    mode_sel_o == RPM_SEL_A && !modulation_type_sel_o) else $error("mode reset value wrong");
  unsupported_off_a: assert property ((mode_sel_o == RPM_SEL_NONE) [*2] |-> !txrx_enable_o)
    else $error("tx/rx left on for bad mode");
endmodule : rpm_config_checker

bind rpm_config rpm_config_checker i_rpm_config_checker (.clock_i, .reset_n_i, .xtal_ok_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .role_target_o, .op_mode_o, .mode_sel_o,
  .modulation_type_sel_o, .transmit_speed_o, .receive_speed_o, .txrx_enable_o);

//--- tb/rpm_host.sv
// APB host model issuing single transfers when the bench asks.
// Assumes the slave answers with pready; waits as long as it takes.
`timescale 1ns/10ps
module rpm_host (
  input wire logic clock_i, // Clock
  input wire logic pready_i, // APB ready
  input wire logic pslverr_i, // APB error
  input wire logic [31:0] prdata_i, // APB read data
  output logic psel_o, // APB select
  output logic penable_o, // APB enable
  output logic pwrite_o, // APB write
  output logic [11:0] paddr_o, // APB address
  output logic [31:0] pwdata_o // APB write data
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  // Callers keep framing off in detect mode, anticollision framing for reader type-A only,
  // and parity-free sends paired with a no-CRC transmit
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clock_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    @(posedge clock_i);
    while (pready_i !== 1'b1) @(posedge clock_i);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released write data must not look valid
    pwdata_o <= ~d;
  endtask : xfer
endmodule : rpm_host

//--- tb/rpm_config_test.sv
// Self-checking bench for rpm_config driven through the APB host model.
// Assumes a 40 MHz clock and write-to-output lag of two edges.
`timescale 1ns/10ps
module rpm_config_test
  import rpm_pkg::*;
;
  logic clock_i, reset_n_i, por_n_i, xtal_ok_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic role_target_o, rate_det_f_o, rate_det_a_o, modulation_type_sel_o, use_passive_target_load_res_o;
  logic txrx_enable_o, no_tx_parity_o, raw_rx_parity_o, transport_frame_format_o, anticoll_frame_o;
  logic [3:0] op_mode_o, mode_sel_o, pulse_width_code_o, x;
  logic [1:0] auto_response_o, transmit_speed_o, receive_speed_o;
  logic [7:0] start_byte_o, op_ctrl_o;
  logic [5:0] pulse_width_periods_o;
  logic [63:0] init_tab = 64'h7600000000054321;
  logic [63:0] tgt_tab = 64'hBBBBBBBBA0090080;
  int fail_count, n_tests, cyc;
  rpm_config i_rpm_config (.clock_i, .reset_n_i, .por_n_i, .xtal_ok_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .role_target_o, .op_mode_o, .mode_sel_o,
    .rate_det_f_o, .rate_det_a_o, .modulation_type_sel_o, .auto_response_o, .use_passive_target_load_res_o,
    .transmit_speed_o, .receive_speed_o, .txrx_enable_o, .no_tx_parity_o, .raw_rx_parity_o,
    .transport_frame_format_o, .start_byte_o, .pulse_width_code_o, .pulse_width_periods_o,
    .anticoll_frame_o, .op_ctrl_o);
  rpm_host i_rpm_host (.clock_i, .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
    n_tests++;
    if (g !== xp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, xp, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_rpm_host.xfer(1'b1, a, d, q, e);
    repeat (2) @(posedge clock_i);
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] xp);
    i_rpm_host.xfer(1'b0, a, 32'h0, q, e);
    chk("rdata", xp, q);
    chk("err", {31'h0, !(a inside {12'h008, 12'h00C, 12'h010, 12'h014})}, e);
  endtask : rd
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    reset_n_i = 1'b0;
    por_n_i = 1'b0;
    xtal_ok_i = 1'b1;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("txrx", 1, txrx_enable_o);
    chk("pw", 35, pulse_width_periods_o);
    rd(12'h00C, 32'h08);
    rd(12'h010, 32'h00);
    rd(12'h014, 32'h00);
    rd(12'h008, 32'h00);
    rd(12'h040, 32'h00);
    rd(12'h408, 32'h00);
    rd(12'h00D, 32'h00);
    for (int r = 0; r < 2; r++) for (int c = 0; c < 16; c++) begin
      x = r ? tgt_tab[c*4 +: 4] : init_tab[c*4 +: 4];
      wr(12'h00C, {r[0], c[3:0], 3'b000});
      chk("sel", x, mode_sel_o);
      chk("load", x inside {4'd8, 4'd9, 4'd11}, use_passive_target_load_res_o);
      if (x != 4'd11) chk("txrx", !(x inside {4'd0, 4'd4, 4'd9}), txrx_enable_o);
      else chk("det", {c[2], c[0]}, {rate_det_f_o, rate_det_a_o});
      rd(12'h00C, {r[0], c[3:0], 3'b000});
    end
    for (int k = 0; k < 8; k++) begin
      wr(12'h00C, {29'h1, k[2:0]});
      chk("mod", k[2], modulation_type_sel_o);
      chk("ar", k[1:0] == 2'b11 ? 2'b00 : k[1:0], auto_response_o);
    end
    @(posedge clock_i);
    xtal_ok_i <= 1'b0;
    wr(12'h00C, 32'hC8);
    rd(12'h00C, 32'h0F);
    @(posedge clock_i);
    xtal_ok_i <= 1'b1;
    wr(12'h00C, 32'h08);
    wr(12'h010, 32'hFFFF_FFFF);
    rd(12'h010, 32'h33);
    chk("txrx", 1, txrx_enable_o);
    wr(12'h00C, 32'h18);
    for (int k = 0; k < 4; k++) begin
      wr(12'h010, {26'h0, k[1:0], 2'b00, k[1:0]});
      chk("tx", k[1:0], transmit_speed_o);
      chk("rx", k[1:0], receive_speed_o);
      chk("txrx", k == 1 || k == 2, txrx_enable_o);
    end
    wr(12'h00C, 32'h08);
    wr(12'h010, 32'h00);
    for (int k = 0; k < 16; k++) begin
      wr(12'h014, {27'h0, k[3:0], 1'b0});
      chk("code", k[3:0], pulse_width_code_o);
      chk("pw", k < 8 ? 35 + k : 19 + k, pulse_width_periods_o);
    end
    wr(12'h014, 32'hE1);
    rd(12'h014, 32'hE1);
    chk("flags", 4'hF, {no_tx_parity_o, raw_rx_parity_o, transport_frame_format_o, anticoll_frame_o});
    chk("sb", 8'hF0, start_byte_o);
    chk("txrx", 1, txrx_enable_o);
    wr(12'h010, 32'h01);
    chk("txrx", 0, txrx_enable_o);
    wr(12'h008, 32'hA5);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk("opc", 8'hA5, op_ctrl_o);
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(12'h008, 32'hA5);
    chk("opc", 8'hA5, op_ctrl_o);
    rd(12'h010, 32'h00);
    rd(12'h00C, 32'h08);
    end_sim();
  end
endmodule : rpm_config_test
